// >>> hdl/video_window_scaler_csc.sv
/*
 Third window zoom, minify, interpolation and colour conversion stage
 with an AHB-Lite register slave.
 Assumes pixels arrive as a valid/ready stream, start and end of line
 marked, and that vblank is high between frames.
*/
// Overview of operation
// - Horizontal zoom only while bit 31 set, factor from bits 26:16.
// - Vertical zoom only while bit 15 set, factor from bits 9:0.
// - Horizontal minify 26:24: 000 none, 001 /2, 011 /4, 101 /8, 111 /16.
// - Vertical minify 18:16 uses the same encoding.
// - Bit 1 clear replicates pixels horizontally, set interpolates.
// - Bit 0 clear replicates lines vertically, set interpolates between lines.
// - Bit 2 picks luma-only or all-component vertical interpolation.
// - Buffer select, reset 11, grants the shared interpolation buffer.
// - Coefficient A, 1.4 unsigned in 28:24, scales luma for all colours.
// - Red is A*Y plus B1*Cb plus C1*Cr plus D, sign-magnitude.
// - D is 11-bit two's complement split across both conversion registers.
// - Green uses 5-bit sign-magnitude B2 in 28:24, C2 in 20:16.
// - Blue uses B3 in 13:8 and C3 in 5:0.
// - Bit 31 picks SD presets, bit 30 HD presets, else programmed.
// - Load bit copies pending settings to the engine in vblank and self-clears on that same edge.
`timescale 1ns/1ps
`default_nettype none
`include "video_window_scaler_csc_regs.svh"
module video_window_scaler_csc (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic vblank,
    input wire logic in_valid,
    input wire logic in_sol,
    input wire logic in_eol,
    input wire logic [7:0] in_y,
    input wire logic [7:0] in_cb,
    input wire logic [7:0] in_cr,
    output logic in_ready,
    output logic out_valid,
    output logic [7:0] out_r,
    output logic [7:0] out_g,
    output logic [7:0] out_b
);
    logic [31:0] zoom_reg, minify_reg, csc1_reg, csc2_reg, compose_reg;
    logic [31:0] zoom_act, minify_act, csc1_act, csc2_act;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic addr_ok, load_done;
    video_window_scaler_csc_pkg::interp_buf_sel_t buf_sel;
    logic hi_en, vi_en, all_c;
    logic [11:0] hstep, hsum;
    logic [9:0] vstep;
    logic [3:0] hmask, vmask, hcnt, hcnt_eff, vcnt, hw, vw;
    logic take, hdrop, hold, line_keep;
    logic [10:0] hacc, xpos, s1_x;
    logic [9:0] vphase;
    video_window_scaler_csc_pkg::comp_t cur_y, cur_cb, cur_cr, prev_y, prev_cb, prev_cr;
    video_window_scaler_csc_pkg::comp_t s1_y, s1_cb, s1_cr, s2_y, s2_cb, s2_cr;
    logic s1_valid, s2_valid;
    logic [23:0] lb [0:2047];
    logic [23:0] lbp;
    logic [4:0] ca, cb2, cc2;
    logic [5:0] cb1, cc1, cb3, cc3;
    logic [10:0] cd;

    function automatic logic [3:0] min_mask(input logic [2:0] c);
        case (c)
            3'h1: min_mask = 4'h1;
            3'h3: min_mask = 4'h3;
            3'h5: min_mask = 4'h7;
            3'h7: min_mask = 4'hF;
            default: min_mask = 4'h0;
        endcase
    endfunction

    function automatic logic [7:0] mix(input logic [7:0] a, input logic [7:0] b,
                                       input logic [3:0] w);
        logic [11:0] t;
        t = 12'(a * (5'h10 - {1'b0, w})) + 12'(b * w);
        mix = t[11:4];
    endfunction

    function automatic logic signed [17:0] sm(input logic [5:0] c);
        sm = c[5] ? -18'sd0 - 18'({c[4:0]}) : 18'({c[4:0]});
    endfunction

    function automatic logic [7:0] csc(input logic [7:0] y, input logic [7:0] u,
                                       input logic [7:0] v, input logic [5:0] b,
                                       input logic [5:0] c);
        logic signed [17:0] acc, tu, tv;
        tu = 18'($signed({1'b0, u}) - $signed(`CHROMA_MID));
        tv = 18'($signed({1'b0, v}) - $signed(`CHROMA_MID));
        acc = $signed(18'({ca})) * $signed(18'({y}))
            + ((sm(b) * tu + sm(c) * tv + 18'($signed(cd))) <<< 1);
        if (acc < 0)
            csc = 8'h00;
        else if (acc[17:12] != 6'h00)
            csc = 8'hFF;
        else
            csc = acc[11:4];
    endfunction

    // Bus address phase
    assign addr_ok = hsel && htrans[1] && hready;
    assign load_done = compose_reg[`LOAD_BIT] && vblank;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h00000000;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_ok && !hwrite)
            begin
                if (haddr == `COMPOSE_OFF)
                    hrdata <= compose_reg;
                else if (haddr == `ZOOM_OFF)
                    hrdata <= zoom_reg;
                else if (haddr == `MINIFY_OFF)
                    hrdata <= minify_reg;
                else if (haddr == `CSC1_OFF)
                    hrdata <= csc1_reg;
                else if (haddr == `CSC2_OFF)
                    hrdata <= csc2_reg;
                else
                    hrdata <= 32'h00000000;
            end
        end
    end

    // Pending settings, write masks drop reserved bits
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            compose_reg <= `COMPOSE_RESET;
            zoom_reg <= `REG_RESET;
            minify_reg <= `REG_RESET;
            csc1_reg <= `REG_RESET;
            csc2_reg <= `REG_RESET;
        end
        else
        begin
            if (load_done)
                compose_reg[`LOAD_BIT] <= 1'b0;
            if (wr_pend)
            begin
                if (wr_addr == `COMPOSE_OFF)
                    compose_reg <= hwdata & `COMPOSE_MASK;
                else if (wr_addr == `ZOOM_OFF)
                    zoom_reg <= hwdata & `ZOOM_MASK;
                else if (wr_addr == `MINIFY_OFF)
                    minify_reg <= hwdata & `MINIFY_MASK;
                else if (wr_addr == `CSC1_OFF)
                    csc1_reg <= hwdata & `CSC1_MASK;
                else if (wr_addr == `CSC2_OFF)
                    csc2_reg <= hwdata & `CSC2_MASK;
            end
        end
    end

    // Engine copy taken at vertical blank
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            zoom_act <= `REG_RESET;
            minify_act <= `REG_RESET;
            csc1_act <= `REG_RESET;
            csc2_act <= `REG_RESET;
        end
        else if (load_done)
        begin
            zoom_act <= zoom_reg;
            minify_act <= minify_reg;
            csc1_act <= csc1_reg;
            csc2_act <= csc2_reg;
        end
    end

    // Mode decode
    always_comb
    begin
        buf_sel = video_window_scaler_csc_pkg::interp_buf_sel_t'(compose_reg[25:24]);
        hi_en = minify_act[`HINT_BIT] && buf_sel[1];
        vi_en = minify_act[`VINT_BIT] && buf_sel[1];
        all_c = minify_act[`ALL_COMP_BIT];
        hstep = (zoom_act[`HZ_EN_BIT] && zoom_act[26:16] != 11'h000)
              ? {1'b0, zoom_act[26:16]} : `HSTEP_ONE;
        vstep = zoom_act[`VZ_EN_BIT] ? zoom_act[9:0] : 10'h000;
        hmask = min_mask(minify_act[26:24]);
        vmask = min_mask(minify_act[18:16]);
    end

    assign take = in_valid && in_ready;
    assign hcnt_eff = in_sol ? 4'h0 : hcnt;
    assign hdrop = (hcnt_eff & hmask) != 4'h0;
    assign hsum = {1'b0, hacc} + hstep;
    assign hw = hacc[10:7];

    // Horizontal minify and zoom
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            in_ready <= 1'b1;
            hold <= 1'b0;
            hcnt <= 4'h0;
            hacc <= 11'h000;
            xpos <= 11'h000;
            {cur_y, cur_cb, cur_cr, prev_y, prev_cb, prev_cr} <= 48'h000000000000;
        end
        else if (take)
        begin
            hcnt <= hcnt_eff + 4'h1;
            if (in_sol)
                xpos <= 11'h000;
            if (!hdrop)
            begin
                {prev_y, prev_cb, prev_cr} <= in_sol ? {in_y, in_cb, in_cr}
                                                     : {cur_y, cur_cb, cur_cr};
                {cur_y, cur_cb, cur_cr} <= {in_y, in_cb, in_cr};
                hold <= 1'b1;
                in_ready <= 1'b0;
                hacc <= 11'h000;
            end
        end
        else if (hold)
        begin
            hacc <= hsum[10:0];
            xpos <= xpos + 11'h001;
            if (hsum[11])
            begin
                hold <= 1'b0;
                in_ready <= 1'b1;
            end
        end
    end

    // Line minify and vertical phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            vcnt <= 4'h0;
            vphase <= 10'h000;
            line_keep <= 1'b1;
            vw <= 4'h0;
        end
        else if (vblank)
        begin
            vcnt <= 4'h0;
            vphase <= 10'h000;
        end
        else if (take)
        begin
            if (in_sol)
            begin
                line_keep <= (vcnt & vmask) == 4'h0;
                vw <= vphase[9:6];
            end
            if (in_eol)
            begin
                vcnt <= vcnt + 4'h1;
                vphase <= vphase + vstep;
            end
        end
    end

    // Previous line store
    assign lbp = lb[s1_x];
    always_ff @(posedge hclk)
    begin
        if (s1_valid)
            lb[s1_x] <= {s1_y, s1_cb, s1_cr};
    end

    // Horizontal and vertical blend stages
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_valid <= 1'b0;
            s2_valid <= 1'b0;
            s1_x <= 11'h000;
            {s1_y, s1_cb, s1_cr, s2_y, s2_cb, s2_cr} <= 48'h000000000000;
        end
        else
        begin
            s1_valid <= hold && !take && line_keep;
            s1_x <= xpos;
            s1_y <= hi_en ? mix(prev_y, cur_y, hw) : cur_y;
            s1_cb <= hi_en ? mix(prev_cb, cur_cb, hw) : cur_cb;
            s1_cr <= hi_en ? mix(prev_cr, cur_cr, hw) : cur_cr;
            s2_valid <= s1_valid;
            s2_y <= vi_en ? mix(s1_y, lbp[23:16], vw) : s1_y;
            s2_cb <= (vi_en && all_c) ? mix(s1_cb, lbp[15:8], vw) : s1_cb;
            s2_cr <= (vi_en && all_c) ? mix(s1_cr, lbp[7:0], vw) : s1_cr;
        end
    end

    // Coefficient source
    always_comb
    begin
        if (csc1_act[`SD_BIT])
        begin
            {ca, cb1, cc1, cb2, cc2, cb3, cc3} =
                {`SD_A, `SD_B1, `SD_C1, `SD_B2, `SD_C2, `SD_B3, `SD_C3};
            cd = `PRESET_D;
        end
        else if (csc1_act[`HD_BIT])
        begin
            {ca, cb1, cc1, cb2, cc2, cb3, cc3} =
                {`HD_A, `HD_B1, `HD_C1, `HD_B2, `HD_C2, `HD_B3, `HD_C3};
            cd = `PRESET_D;
        end
        else
        begin
            ca = csc1_act[28:24];
            cb1 = csc1_act[21:16];
            cc1 = csc1_act[13:8];
            cb2 = csc2_act[28:24];
            cc2 = csc2_act[20:16];
            cb3 = csc2_act[13:8];
            cc3 = csc2_act[5:0];
            cd = {csc1_act[7:0], csc2_act[31:29]};
        end
    end

    // Conversion and clamp
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            out_valid <= 1'b0;
            out_r <= 8'h00;
            out_g <= 8'h00;
            out_b <= 8'h00;
        end
        else
        begin
            out_valid <= s2_valid;
            out_r <= csc(s2_y, s2_cb, s2_cr, cb1, cc1);
            out_g <= csc(s2_y, s2_cb, s2_cr, {cb2[4], 1'b0, cb2[3:0]},
                         {cc2[4], 1'b0, cc2[3:0]});
            out_b <= csc(s2_y, s2_cb, s2_cr, cb3, cc3);
        end
    end

    default clocking dcb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_load_clear: assert property (load_done && !wr_pend |=> !compose_reg[`LOAD_BIT])
        else $error("load bit not cleared");
    a_load_copy: assert property (load_done |=> zoom_act == $past(zoom_reg))
        else $error("settings not copied at load");
    a_hzoom_off: assert property (hold && !take && !zoom_act[`HZ_EN_BIT] |=> in_ready)
        else $error("pixel repeated without zoom");
    a_hmin_drop: assert property (take && hdrop |=> in_ready && $stable(cur_y))
        else $error("minified pixel not dropped");
    a_vmin_line: assert property (take && in_sol && !in_eol && !vblank
                                  |=> line_keep == ((vcnt & vmask) == 4'h0))
        else $error("line keep wrong");
    a_hrepl: assert property (hold && !take && !hi_en |=> s1_y == $past(cur_y))
        else $error("horizontal replication broken");
    a_vrepl: assert property (s1_valid && !vi_en |=> s2_y == $past(s1_y, 1))
        else $error("vertical replication broken");
    a_luma_only: assert property (s1_valid && !all_c |=> s2_cb == $past(s1_cb))
        else $error("chroma interpolated in luma-only mode");
    a_buf_gate: assert property (!compose_reg[25] |-> !hi_en && !vi_en)
        else $error("interpolation without buffer");
    a_sd_preset: assert property (csc1_act[`SD_BIT] |-> ca == `SD_A && cd == `PRESET_D)
        else $error("preset not applied");
    a_rsv_read: assert property (addr_ok && !hwrite && haddr == `ZOOM_OFF
                                 |=> hrdata[30:27] == 4'h0 && hrdata[14:10] == 5'h00)
        else $error("reserved bits read nonzero");
    a_pipe_out: assert property (s1_valid |=> ##1 out_valid)
        else $error("pixel lost in conversion");

    c_load: cover property (load_done);
    c_zoom_repeat: cover property (hold && !hsum[11] && zoom_act[`HZ_EN_BIT]);
    c_vinterp: cover property (s1_valid && vi_en && all_c);
    c_clamp: cover property (s2_valid && s2_y == 8'hFF);
endmodule // video_window_scaler_csc
`default_nettype wire

// >>> hdl/video_window_scaler_csc_regs.svh
/*
 Register offsets, field positions, write masks, reset values and
 conversion presets of the third window scaler and converter.
 Assumes inclusion by bare name from the hdl folder.
*/
`ifndef VIDEO_WINDOW_SCALER_CSC_REGS_SVH
`define VIDEO_WINDOW_SCALER_CSC_REGS_SVH
`define COMPOSE_OFF 32'h00000298
`define ZOOM_OFF 32'h000002BC
`define MINIFY_OFF 32'h000002C0
`define CSC1_OFF 32'h000002C4
`define CSC2_OFF 32'h000002C8
`define COMPOSE_MASK 32'h43000000
`define ZOOM_MASK 32'h87FF83FF
`define MINIFY_MASK 32'h07070007
`define CSC1_MASK 32'hDF3F3FFF
`define CSC2_MASK 32'hFF1F3F3F
`define COMPOSE_RESET 32'h03000000
`define REG_RESET 32'h00000000
`define LOAD_BIT 30
`define HZ_EN_BIT 31
`define VZ_EN_BIT 15
`define ALL_COMP_BIT 2
`define HINT_BIT 1
`define VINT_BIT 0
`define SD_BIT 31
`define HD_BIT 30
`define HSTEP_ONE 12'h800
`define CHROMA_MID 9'h080
`define SD_A 5'h13
`define SD_B1 6'h00
`define SD_C1 6'h0D
`define SD_B2 5'h13
`define SD_C2 5'h17
`define SD_B3 6'h10
`define SD_C3 6'h00
`define HD_A 5'h13
`define HD_B1 6'h00
`define HD_C1 6'h0E
`define HD_B2 5'h12
`define HD_C2 5'h14
`define HD_B3 6'h11
`define HD_C3 6'h00
`define PRESET_D 11'h76B
`endif

// >>> hdl/video_window_scaler_csc_pkg.sv
/*
 Types of the third window scaler and converter.
 Assumes nothing of its surroundings.
*/
package video_window_scaler_csc_pkg;
    typedef logic [7:0] comp_t;
    typedef enum logic [1:0] {buf_unused, buf_first_hd, buf_third_hd, buf_both_sd} interp_buf_sel_t;
endpackage

// >>> testbench/pixel_fetch_model.sv
/*
 Fetch side model: offers YCbCr pixels as a held valid stream.
 Assumes in_ready is sampled at rising hclk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module pixel_fetch_model (
    input wire logic hclk,
    input wire logic in_ready,
    output var logic in_valid,
    output var logic in_sol,
    output var logic in_eol,
    output var logic [7:0] in_y,
    output var logic [7:0] in_cb,
    output var logic [7:0] in_cr
);
    initial
    begin
        {in_valid, in_sol, in_eol} = 3'h0;
        {in_y, in_cb, in_cr} = 24'h000000;
    end

    // Holds a pixel until taken, then idles or goes straight on
    task automatic send(input logic [23:0] px, input logic sol, input logic eol, input int gap);
        int n;
        in_valid <= 1'b1;
        in_sol <= sol;
        in_eol <= eol;
        {in_y, in_cb, in_cr} <= px;
        for (n = 0; n < 64; n++)
        begin
            @(posedge hclk);
            if (in_ready === 1'b1)
                break;
        end
        if (gap > 0 || eol)
        begin
            in_valid <= 1'b0;
            {in_y, in_cb, in_cr} <= ~px;
            repeat (gap + 1) @(posedge hclk);
        end
    endtask
endmodule // pixel_fetch_model
`default_nettype wire

// >>> testbench/test_video_window_scaler_csc.sv
/*
 Self-checking bench of the third window scaler and converter.
 Assumes the register header is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "video_window_scaler_csc_regs.svh"
module test_video_window_scaler_csc;
    logic hclk, hresetn, hsel, hwrite, vblank, hresp, out_valid, rd_ph;
    logic in_valid, in_sol, in_eol, in_ready;
    logic [31:0] haddr, hwdata, hrdata, w;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] in_y, in_cb, in_cr, out_r, out_g, out_b;
    logic [23:0] px;
    wire logic hready;
    int n_mismatch = 0;
    int samples_checked = 0;
    integer seed = 32'hB266;
    logic [31:0] rd_q[$];
    logic [23:0] px_q[$];
    logic [31:0] offs[4] = '{`ZOOM_OFF, `MINIFY_OFF, `CSC1_OFF, `CSC2_OFF};
    logic [31:0] msks[4] = '{`ZOOM_MASK, `MINIFY_MASK, `CSC1_MASK, `CSC2_MASK};
    // A, red cb/cr, green cb/cr, blue cb/cr in eighths, A in sixteenths, D in eighths
    int coef[5][8] = '{'{16, 0, 0, 0, 0, 0, 0, 128}, '{16, 8, -8, -8, 8, 8, -8, -128},
        '{8, 16, 0, 0, -8, 24, -16, 0}, '{int'(`SD_A), 0, 0, 0, 0, 0, 0, int'($signed(`PRESET_D))},
        '{int'(`HD_A), 0, 0, 0, 0, 0, 0, int'($signed(`PRESET_D))}};
    // Zoom, minify, pixels per line, lines, outputs
    int sc[9][5] = '{'{32'h84000000, 0, 4, 1, 8}, '{32'h04000000, 0, 4, 1, 4},
        '{0, 32'h00000000, 16, 1, 16}, '{0, 32'h01000000, 16, 1, 8},
        '{0, 32'h03000000, 16, 1, 4}, '{0, 32'h05000000, 16, 1, 2},
        '{0, 32'h07000000, 16, 1, 1}, '{0, 32'h00010000, 2, 4, 4},
        '{32'h84000000, 32'h00000007, 4, 2, 16}};

    video_window_scaler_csc i_video_window_scaler_csc (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .vblank(vblank), .in_valid(in_valid), .in_sol(in_sol), .in_eol(in_eol), .in_y(in_y),
        .in_cb(in_cb), .in_cr(in_cr), .in_ready(in_ready), .out_valid(out_valid),
        .out_r(out_r), .out_g(out_g), .out_b(out_b));

    pixel_fetch_model i_pixel_fetch_model (.hclk(hclk), .in_ready(in_ready),
        .in_valid(in_valid), .in_sol(in_sol), .in_eol(in_eol), .in_y(in_y), .in_cb(in_cb),
        .in_cr(in_cr));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wait_ready;
        int n;
        for (n = 0; n < 64; n++)
        begin
            @(posedge hclk);
            if (hready === 1'b1)
                break;
        end
        if (n == 64)
            n_mismatch++;
    endtask

    // One single word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= addr;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
    endtask

    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, addr, 32'h00000000);
    endtask

    // Writes all settings and applies them during vblank
    task automatic load(input logic [31:0] z, mi, c1, c2);
        bus(1'b1, `ZOOM_OFF, z);
        bus(1'b1, `MINIFY_OFF, mi);
        bus(1'b1, `CSC1_OFF, c1);
        bus(1'b1, `CSC2_OFF, c2);
        bus(1'b1, `COMPOSE_OFF, 32'h43000000);
        vblank <= 1'b1;
        repeat (2) @(posedge hclk);
        vblank <= 1'b0;
        rd(`COMPOSE_OFF, `COMPOSE_RESET);
    endtask

    task automatic drain;
        for (int n = 0; n < 300 && px_q.size() > 0; n++)
            @(posedge hclk);
        repeat (8) @(posedge hclk);
        check(px_q.size(), 32'h00000000);
    endtask

    function automatic logic [5:0] sm(input int v);
        sm = v < 0 ? {1'b1, 5'(-v)} : 6'(v);
    endfunction

    function automatic logic [23:0] conv(input int c[8], input logic [23:0] p);
        int s;
        for (int k = 0; k < 3; k++)
        begin
            s = c[0] * int'(p[23:16]) + 2 * c[7] + 2 * c[1 + 2 * k] * (int'(p[15:8]) - 128)
                + 2 * c[2 + 2 * k] * (int'(p[7:0]) - 128);
            s = s >>> 4;
            conv[23 - 8 * k -: 8] = s < 0 ? 8'h00 : s > 255 ? 8'hFF : 8'(s);
        end
    endfunction

    // Watches read data phases and output pixels
    always @(posedge hclk)
    begin
        if (rd_ph && hready)
        begin
            check(hrdata, rd_q.pop_front());
            check({31'h0, hresp}, 32'h00000000);
        end
        rd_ph <= hsel && htrans[1] && !hwrite && hready;
        if (out_valid === 1'b1)
            check({8'h00, out_r, out_g, out_b}, px_q.size() > 0 ? {8'h00, px_q.pop_front()} : 32'hX);
    end

    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    initial
    begin
        repeat (40000) @(posedge hclk);
        n_mismatch++;
        tally_and_finish();
    end

    initial
    begin
        logic [10:0] d;
        logic [1:0] pre;
        logic [31:0] c1, c2;
        logic [5:0] gb, gr;
        {hresetn, hsel, hwrite, vblank} = 4'h0;
        {haddr, hwdata} = 64'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`COMPOSE_OFF, `COMPOSE_RESET);
        bus(1'b1, 32'h000002CC, 32'hFFFFFFFF);
        rd(32'h000002CC, 32'h00000000);
        for (int k = 0; k < 4; k++)
        begin
            rd(offs[k], `REG_RESET);
            w = $random(seed);
            bus(1'b1, offs[k], w);
            rd(offs[k], w & msks[k]);
            bus(1'b1, offs[k], 32'hFFFFFFFF);
            rd(offs[k], msks[k]);
        end
        bus(1'b1, `COMPOSE_OFF, 32'h43000000);
        rd(`COMPOSE_OFF, 32'h43000000);
        for (int t = 0; t < 5; t++)
        begin
            d = 11'(coef[t][7]);
            pre = t == 3 ? 2'h2 : t == 4 ? 2'h1 : 2'h0;
            c1 = {2'h0, 1'b0, 5'(coef[t][0]), 2'h0, sm(coef[t][1]), 2'h0, sm(coef[t][2]), d[10:3]};
            gb = sm(coef[t][3]);
            gr = sm(coef[t][4]);
            c2 = {d[2:0], gb[5], gb[3:0], 3'h0, gr[5], gr[3:0], 2'h0, sm(coef[t][5]), 2'h0,
                sm(coef[t][6])};
            if (pre != 2'h0)
                {c1, c2} = {pre, 62'h0};
            load(32'h00000000, 32'h00000000, c1, c2);
            for (int i = 0; i < 8; i++)
            begin
                px = $random(seed);
                if (t == 2)
                    px[16] = 1'b0;
                if (t > 2)
                    px[19:0] = 20'h08080;
                px_q.push_back(conv(coef[t], px));
                i_pixel_fetch_model.send(px, i == 0, i == 7, i % 3);
            end
            drain();
        end
        foreach (sc[t])
        begin
            load(sc[t][0], sc[t][1], 32'h10000010, 32'h00000000);
            repeat (sc[t][4]) px_q.push_back(24'h505050);
            repeat (sc[t][3])
                for (int i = 0; i < sc[t][2]; i++)
                    i_pixel_fetch_model.send(24'h408080, i == 0, i == sc[t][2] - 1, 0);
            drain();
        end
        // Horizontal interpolation at 2x zoom on a luma ramp
        load(32'h84000000, 32'h00000002, 32'h10000010, 32'h00000000);
        for (int i = 0; i < 8; i++)
            px_q.push_back({3{i < 3 ? 8'h30 : 8'(16 * i + 16)}});
        for (int i = 0; i < 4; i++)
            i_pixel_fetch_model.send({8'(32 * i + 32), 16'h8080}, i == 0, i == 3, 0);
        drain();
        tally_and_finish();
    end
endmodule // test_video_window_scaler_csc
`default_nettype wire
